// *** ppcx_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module ppcx_checker
   import ppcx_pkg::*;
(
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic       sfr_rmw,
   input wire logic       sfr_page,
   input wire logic       reset_pin_disable,
   input wire logic [7:0] port3_pins,
   input wire logic       irq0_vector_ack,
   input wire logic [7:0] sfr_rdata,
   input wire logic [7:0] port0_latch,
   input wire logic       pin20_pullup_on,
   input wire logic       timer0_pin_oe_n,
   input wire logic       timer1_pin_oe_n,
   input wire logic       ext_irq0_req,
   input wire logic       wake_req
);
   // ----------------------------------------
   // Shadow of trigger mode and enables
   // ----------------------------------------
   logic       edge_reg;
   logic [1:0] en_reg;
   wire logic  p2_wr = sfr_wr && sfr_addr == PPCX_ADDR_P2_SET;
   wire logic  paged = sfr_addr inside {8'h82, 8'h83, 8'h84, 8'hac, 8'had, 8'hb1};
   always_ff @(posedge clk) begin
      if (sys_rst) edge_reg <= 1'b0;
      else if (sfr_wr && sfr_addr == PPCX_ADDR_TIMER_CONTROL_REG) edge_reg <= sfr_wdata[PPCX_IT0_BIT];
   end
   always_ff @(posedge clk) begin
      if (sys_rst) en_reg <= 2'h0;
      else if (sfr_wr && sfr_addr == PPCX_ADDR_IE) en_reg <= {sfr_wdata[7], sfr_wdata[0]};
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_p2_reserved: assert property (sfr_rd && sfr_addr == PPCX_ADDR_P2_SET |=> (sfr_rdata & 8'h72) == 8'h00)
      else $error("reserved setting bits read non-zero");
   a_timer_route:
      assert property (p2_wr |-> ##2 {timer1_pin_oe_n, timer0_pin_oe_n} == ~$past(sfr_wdata[3:2], 2))
      else $error("timer pin enable does not follow setting");
   a_pullup_forced: assert property (!reset_pin_disable [*2] |-> pin20_pullup_on)
      else $error("pull-up off while pin is reset pin");
   a_page_block: assert property (sfr_rd && !sfr_page && paged |=> sfr_rdata == 8'h00)
      else $error("paged register visible off page");
   a_rmw_latch: assert property (sfr_rmw && sfr_addr == PPCX_ADDR_PORT0 |=> sfr_rdata == $past(port0_latch))
      else $error("rmw read not from latch");
   a_edge_wake:
      assert property (($fell(port3_pins[0]) && edge_reg && en_reg[0]) ##1 !sfr_wr [*3] |=> wake_req)
      else $error("falling edge did not raise wake");
   a_edge_ack:
      assert property ((edge_reg && port3_pins[0]) [*4] ##0 (irq0_vector_ack && !sfr_wr) |=> ##1 !ext_irq0_req)
      else $error("edge flag not cleared by vector");
   a_level_idle: assert property ((!edge_reg && port3_pins[0]) [*5] |-> !ext_irq0_req)
      else $error("level request with pin high");
   a_level_req: assert property ((!edge_reg && en_reg == 2'h3 && !port3_pins[0]) [*5] |-> ext_irq0_req)
      else $error("level request missing with pin low");
   c_edge_req: cover property (ext_irq0_req && edge_reg);
   c_level_req: cover property (ext_irq0_req && !edge_reg);
   c_rmw_read: cover property (sfr_rmw);
endmodule
bind ppcx_top ppcx_checker ppcx_checker_i (.*);
`default_nettype wire

// *** ppcx_pins_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ppcx_pins_model (
   input  wire logic [1:0] irq_lvl,
   input  wire logic [7:0] pattern,
   output logic [7:0]      port0_pins,
   output logic [7:0]      port1_pins,
   output logic [7:0]      port3_pins,
   output logic            pin20_in
);
   // Pads are always driven: a floating input-only pin has no defined level
   assign port0_pins = pattern;
   assign port1_pins = {irq_lvl[1], pattern[6:0]};
   assign port3_pins = {pattern[7:1], irq_lvl[0]};
   assign pin20_in   = pattern[0];
endmodule
`default_nettype wire

// *** ppcx_pkg.sv ***
package ppcx_pkg;

   // ----------------------------------------
   // Register addresses (8-bit SFR space)
   // ----------------------------------------
   localparam logic [7:0] PPCX_ADDR_P0_SLEW   = 8'h82;
   localparam logic [7:0] PPCX_ADDR_P1_ITYPE  = 8'h83;
   localparam logic [7:0] PPCX_ADDR_P1_SLEW   = 8'h84;
   localparam logic [7:0] PPCX_ADDR_P3_ITYPE  = 8'hac;
   localparam logic [7:0] PPCX_ADDR_P3_SLEW   = 8'had;
   localparam logic [7:0] PPCX_ADDR_P0_ITYPE  = 8'hb1;
   localparam logic [7:0] PPCX_ADDR_P2_SET    = 8'hb5;
   localparam logic [7:0] PPCX_ADDR_TIMER_CONTROL_REG      = 8'h88;
   localparam logic [7:0] PPCX_ADDR_IE        = 8'ha8;
   localparam logic [7:0] PPCX_ADDR_PORT0     = 8'h80;
   localparam logic [7:0] PPCX_ADDR_PORT1     = 8'h90;
   localparam logic [7:0] PPCX_ADDR_PORT2     = 8'ha0;
   localparam logic [7:0] PPCX_ADDR_PORT3     = 8'hb0;

   // ----------------------------------------
   // Paging and field positions
   // ----------------------------------------
   localparam logic       PPCX_PAGE_CFG       = 1'b1;
   localparam int         PPCX_P2_PULLUP_BIT  = 7;
   localparam int         PPCX_P2_T1OE_BIT    = 3;
   localparam int         PPCX_P2_TIMER0_OUTPUT_ENABLE_BIT    = 2;
   localparam int         PPCX_P2_ITYPE_BIT   = 0;
   localparam logic [7:0] PPCX_P2_WMASK       = 8'h8d;
   localparam int         PPCX_IT0_BIT        = 0;
   localparam int         PPCX_IE0_BIT        = 1;
   localparam int         PPCX_IT1_BIT        = 2;
   localparam int         PPCX_IE1_BIT        = 3;
   localparam int         PPCX_EX0_BIT        = 0;
   localparam int         PPCX_EX1_BIT        = 2;
   localparam int         PPCX_EA_BIT         = 7;
   localparam int         PPCX_IRQ1_PIN       = 7;
   localparam int         PPCX_IRQ0_PIN       = 0;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] PPCX_RST_CFG        = 8'h00;
   localparam logic [7:0] PPCX_RST_LATCH      = 8'hff;
   localparam logic [3:0] PPCX_RST_TIMER_CONTROL_REG_LO    = 4'h0;

   typedef enum logic [1:0] {
      PPCX_OP_READ,
      PPCX_OP_WRITE,
      PPCX_OP_RMW
   } ppcx_op_t;

endpackage

// *** ppcx_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb
   import ppcx_pkg::*;
;
   logic       clk, sys_rst, sfr_wr, sfr_rd, sfr_rmw, sfr_page, reset_pin_disable;
   logic       irq0_vector_ack, irq1_vector_ack, timer0_out, timer1_out, pin20_in;
   logic [7:0] sfr_addr, sfr_wdata, port0_pins, port1_pins, port3_pins, pattern;
   logic [7:0] sfr_rdata, port0_latch, port1_latch, port3_latch;
   logic [7:0] port0_input_type, port1_input_type, port3_input_type;
   logic [7:0] port0_slew_select, port1_slew_select, port3_slew_select;
   logic       pin20_pullup_on, pin20_input_type, timer0_pin_out, timer0_pin_oe_n;
   logic       timer1_pin_out, timer1_pin_oe_n, ext_irq0_req, ext_irq1_req, wake_req;
   logic [1:0] irq_lvl;
   logic [7:0] v [6];
   logic [7:0] pg_addr [6] = '{8'h82, 8'h83, 8'h84, 8'hac, 8'had, 8'hb1};
   logic [7:0] pt_addr [3] = '{PPCX_ADDR_PORT0, PPCX_ADDR_PORT1, PPCX_ADDR_PORT3};
   int         failures = 0;
   int         check_count = 0;
   wire logic [47:0] cfg_outs = {port0_input_type, port1_input_type, port3_input_type,
                                 port0_slew_select, port1_slew_select, port3_slew_select};
   wire logic [5:0]  p2_outs = {pin20_pullup_on, pin20_input_type, timer1_pin_oe_n,
                                timer0_pin_oe_n, timer1_pin_out, timer0_pin_out};
   wire logic [2:0]  irq_outs = {wake_req, ext_irq1_req, ext_irq0_req};
   ppcx_top ppcx_top_i (.*);
   ppcx_pins_model ppcx_pins_model_i (.*);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ----------------------------------------
   // Access and compare tasks
   // ----------------------------------------
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Strobes drop one cycle later, so back-to-back calls never re-drive in one step
   task automatic acc(input logic w, input logic r, input logic m, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, sfr_rmw} = {a, d, w, r, m};
      @(negedge clk);
      {sfr_wr, sfr_rd, sfr_rmw} = 3'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      acc(1'b1, 1'b0, 1'b0, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic m);
      acc(1'b0, !m, m, a, 8'h00);
      chk(48'(sfr_rdata), 48'(e));
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic vec(input int i);
      {irq1_vector_ack, irq0_vector_ack} = 2'(i + 1);
      cyc(1);
      {irq1_vector_ack, irq0_vector_ack} = 2'h0;
      cyc(3);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      tally_and_finish();
   end
   initial begin
      {sys_rst, sfr_wr, sfr_rd, sfr_rmw, sfr_page, reset_pin_disable} = 6'b100011;
      {irq0_vector_ack, irq1_vector_ack, timer0_out, timer1_out} = 4'h0;
      {sfr_addr, sfr_wdata, pattern, irq_lvl} = {8'h00, 8'h00, 8'hc3, 2'h3};
      cyc(20);
      sys_rst = 1'b0;
      for (int i = 0; i < 6; i++) rd(pg_addr[i], 8'h00, 1'b0);
      rd(PPCX_ADDR_P2_SET, 8'h00, 1'b0);
      for (int i = 0; i < 6; i++) begin
         v[i] = 8'h5a ^ 8'(i * 37);
         wr(pg_addr[i], v[i]);
         sfr_page = 1'b0;
         wr(pg_addr[i], 8'hff);
         rd(pg_addr[i], 8'h00, 1'b0);
         sfr_page = 1'b1;
         rd(pg_addr[i], v[i], 1'b0);
      end
      chk(cfg_outs, {v[5], v[1], v[3], v[0], v[2], v[4]});
      // Both timers are taken to run as timers here
      {timer1_out, timer0_out} = 2'b01;
      wr(PPCX_ADDR_P2_SET, 8'hff);
      rd(PPCX_ADDR_P2_SET, 8'h8d, 1'b0);
      cyc(2);
      chk(48'(p2_outs), 48'h31);
      wr(PPCX_ADDR_P2_SET, 8'h00);
      cyc(2);
      chk(48'(p2_outs[5:2]), 48'h3);
      rd(PPCX_ADDR_PORT2, 8'h01, 1'b0);
      reset_pin_disable = 1'b0;
      cyc(2);
      chk(48'(pin20_pullup_on), 48'h1);
      rd(PPCX_ADDR_PORT2, 8'h00, 1'b0);
      reset_pin_disable = 1'b1;
      for (int i = 0; i < 3; i++) begin
         wr(pt_addr[i], 8'h3c ^ 8'(i));
         rd(pt_addr[i], 8'h3c ^ 8'(i), 1'b1);
      end
      rd(PPCX_ADDR_PORT0, 8'hc3, 1'b0);
      wr(PPCX_ADDR_PORT0, 8'h3c | 8'h01);
      chk(48'(port0_latch), 48'h3d);
      wr(PPCX_ADDR_IE, 8'h85);
      for (int i = 0; i < 2; i++) begin
         wr(PPCX_ADDR_TIMER_CONTROL_REG, 8'h05);
         irq_lvl[i] = 1'b0; // Low for one whole cycle
         cyc(1);
         irq_lvl[i] = 1'b1;
         cyc(5);
         chk(48'(irq_outs), 48'(3'h4 + 3'(i + 1)));
         rd(PPCX_ADDR_TIMER_CONTROL_REG, 8'(8'h07 + 8'(6 * i)), 1'b0);
         vec(i);
         chk(48'(irq_outs), 48'h0);
         wr(PPCX_ADDR_TIMER_CONTROL_REG, 8'h00);
         irq_lvl[i] = 1'b0; // Held low across service
         cyc(6);
         chk(48'(irq_outs), 48'(3'h4 + 3'(i + 1)));
         vec(i);
         rd(PPCX_ADDR_TIMER_CONTROL_REG, 8'(8'h02 + 8'(6 * i)), 1'b0);
         wr(PPCX_ADDR_IE, 8'h05);
         cyc(2);
         chk(48'(irq_outs), 48'h4);
         wr(PPCX_ADDR_IE, 8'h85);
         irq_lvl[i] = 1'b1;
         cyc(6);
         chk(48'(irq_outs), 48'h0);
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire

// *** ppcx_top.sv ***
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Every pin of ports 0, 1, 3 has TTL/Schmitt select bit.
// - Port-2 setting bit 7 enables P2.0 pull-up; forced on as reset pin.
// - Port-2 setting bit 3 routes timer 1 output to its pin.
// - Port-2 setting bit 2 routes timer 0 output to its pin.
// - Port-2 setting bit 0 selects P2.0 input type; set means Schmitt.
// - Every pin of ports 0, 1, 3 has slew bit, reset normal.
// - Input-type and slew registers reachable only on page 1.
// - Read-modify-write on a port reads the output latch, not pins.
// - Logic, jump-clear, complement, inc, dec, djnz use latch reads.
// - Bit move, clear, set rewrite whole latch changing one bit.
// - Timer control bits 0 and 2 choose edge or level per input.
// - Timer control bits 1 and 3 hold external request flags.
// - Edge mode sets flag on high sample followed by low sample.
// - Edge mode flag clears when its service routine is entered.
// - Level mode flag mirrors inverted pin, no clear on entry.
// - Input still low after service requests again.
// - Either external request wakes the device from power-down.
// - P2.0 is general input when reset pin disabled, else reads 0.
// - Input 1 from P1.7, enabled by enable bit 2 and bit 7.
// - Input 0 from P3.0, enabled by enable bit 0 and bit 7.
module ppcx_top
   import ppcx_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic [7:0] sfr_addr,
   input  wire logic [7:0] sfr_wdata,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic       sfr_rmw,
   input  wire logic       sfr_page,
   input  wire logic       reset_pin_disable,
   input  wire logic [7:0] port0_pins,
   input  wire logic [7:0] port1_pins,
   input  wire logic [7:0] port3_pins,
   input  wire logic       pin20_in,
   input  wire logic       irq0_vector_ack,
   input  wire logic       irq1_vector_ack,
   input  wire logic       timer0_out,
   input  wire logic       timer1_out,
   output logic [7:0]      sfr_rdata,
   output logic [7:0]      port0_latch,
   output logic [7:0]      port1_latch,
   output logic [7:0]      port3_latch,
   output logic [7:0]      port0_input_type,
   output logic [7:0]      port1_input_type,
   output logic [7:0]      port3_input_type,
   output logic [7:0]      port0_slew_select,
   output logic [7:0]      port1_slew_select,
   output logic [7:0]      port3_slew_select,
   output logic            pin20_pullup_on,
   output logic            pin20_input_type,
   output logic            timer0_pin_out,
   output logic            timer0_pin_oe_n,
   output logic            timer1_pin_out,
   output logic            timer1_pin_oe_n,
   output logic            ext_irq0_req,
   output logic            ext_irq1_req,
   output logic            wake_req
);

   // ----------------------------------------
   // Local state
   // ----------------------------------------
   logic [7:0] p2_set_reg;
   logic [3:0] timer_control_reg_lo_reg;
   logic [1:0] ie_bits_reg;
   logic       ea_reg;
   logic [1:0] sync1_reg;
   logic [1:0] sync2_reg;
   logic [1:0] prev_reg;
   logic [7:0] rdata_next;
   logic       cfg_page;
   logic       wr_ok;

   assign cfg_page = (sfr_page == PPCX_PAGE_CFG);
   assign wr_ok    = sfr_wr;

   function automatic logic cfg_hit(input logic [7:0] a, input logic [7:0] reg_a, input logic pg);
      cfg_hit = (a == reg_a) && pg;
   endfunction

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         port0_input_type  <= PPCX_RST_CFG;
         port1_input_type  <= PPCX_RST_CFG;
         port3_input_type  <= PPCX_RST_CFG;
         port0_slew_select <= PPCX_RST_CFG;
         port1_slew_select <= PPCX_RST_CFG;
         port3_slew_select <= PPCX_RST_CFG;
      end else if (wr_ok) begin
         // Paged registers ignore writes off page 1
         if (cfg_hit(sfr_addr, PPCX_ADDR_P0_ITYPE, cfg_page)) begin
            port0_input_type <= sfr_wdata;
         end else if (cfg_hit(sfr_addr, PPCX_ADDR_P1_ITYPE, cfg_page)) begin
            port1_input_type <= sfr_wdata;
         end else if (cfg_hit(sfr_addr, PPCX_ADDR_P3_ITYPE, cfg_page)) begin
            port3_input_type <= sfr_wdata;
         end else if (cfg_hit(sfr_addr, PPCX_ADDR_P0_SLEW, cfg_page)) begin
            port0_slew_select <= sfr_wdata;
         end else if (cfg_hit(sfr_addr, PPCX_ADDR_P1_SLEW, cfg_page)) begin
            port1_slew_select <= sfr_wdata;
         end else if (cfg_hit(sfr_addr, PPCX_ADDR_P3_SLEW, cfg_page)) begin
            port3_slew_select <= sfr_wdata;
         end
      end
   end

   // Port-2 setting lives on all pages
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         p2_set_reg <= PPCX_RST_CFG;
      end else if (wr_ok && sfr_addr == PPCX_ADDR_P2_SET) begin
         p2_set_reg <= sfr_wdata & PPCX_P2_WMASK;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin20_pullup_on  <= 1'b1;
         pin20_input_type <= 1'b0;
         timer0_pin_out   <= 1'b0;
         timer0_pin_oe_n  <= 1'b1;
         timer1_pin_out   <= 1'b0;
         timer1_pin_oe_n  <= 1'b1;
      end else begin
         // As reset pin the pull-up cannot be turned off
         pin20_pullup_on  <= !reset_pin_disable || p2_set_reg[PPCX_P2_PULLUP_BIT];
         pin20_input_type <= p2_set_reg[PPCX_P2_ITYPE_BIT];
         timer0_pin_out   <= timer0_out;
         timer0_pin_oe_n  <= !p2_set_reg[PPCX_P2_TIMER0_OUTPUT_ENABLE_BIT];
         timer1_pin_out   <= timer1_out;
         timer1_pin_oe_n  <= !p2_set_reg[PPCX_P2_T1OE_BIT];
      end
   end

   // ----------------------------------------
   // Port output latches
   // ----------------------------------------
   // The CPU does the modify step; a write always carries the full byte,
   // built from a latch read, so bit ops rewrite the whole latch.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         port0_latch <= PPCX_RST_LATCH;
         port1_latch <= PPCX_RST_LATCH;
         port3_latch <= PPCX_RST_LATCH;
      end else if (wr_ok) begin
         if (sfr_addr == PPCX_ADDR_PORT0) begin
            port0_latch <= sfr_wdata;
         end else if (sfr_addr == PPCX_ADDR_PORT1) begin
            port1_latch <= sfr_wdata;
         end else if (sfr_addr == PPCX_ADDR_PORT3) begin
            port3_latch <= sfr_wdata;
         end
      end
   end

   // ----------------------------------------
   // External interrupt detection
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sync1_reg <= 2'h3;
         sync2_reg <= 2'h3;
         prev_reg  <= 2'h3;
      end else begin
         sync1_reg <= {port1_pins[PPCX_IRQ1_PIN], port3_pins[PPCX_IRQ0_PIN]};
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         timer_control_reg_lo_reg <= PPCX_RST_TIMER_CONTROL_REG_LO;
      end else begin
         if (wr_ok && sfr_addr == PPCX_ADDR_TIMER_CONTROL_REG) begin
            timer_control_reg_lo_reg[PPCX_IT0_BIT] <= sfr_wdata[PPCX_IT0_BIT];
            timer_control_reg_lo_reg[PPCX_IT1_BIT] <= sfr_wdata[PPCX_IT1_BIT];
         end
         // Flag 0: level mode mirrors inverted pin, edge mode is sticky; set beats clear
         if (!timer_control_reg_lo_reg[PPCX_IT0_BIT]) begin
            timer_control_reg_lo_reg[PPCX_IE0_BIT] <= !sync2_reg[0];
         end else if (prev_reg[0] && !sync2_reg[0]) begin
            timer_control_reg_lo_reg[PPCX_IE0_BIT] <= 1'b1;
         end else if (irq0_vector_ack) begin
            timer_control_reg_lo_reg[PPCX_IE0_BIT] <= 1'b0;
         end else if (wr_ok && sfr_addr == PPCX_ADDR_TIMER_CONTROL_REG) begin
            timer_control_reg_lo_reg[PPCX_IE0_BIT] <= sfr_wdata[PPCX_IE0_BIT];
         end
         if (!timer_control_reg_lo_reg[PPCX_IT1_BIT]) begin
            timer_control_reg_lo_reg[PPCX_IE1_BIT] <= !sync2_reg[1];
         end else if (prev_reg[1] && !sync2_reg[1]) begin
            timer_control_reg_lo_reg[PPCX_IE1_BIT] <= 1'b1;
         end else if (irq1_vector_ack) begin
            timer_control_reg_lo_reg[PPCX_IE1_BIT] <= 1'b0;
         end else if (wr_ok && sfr_addr == PPCX_ADDR_TIMER_CONTROL_REG) begin
            timer_control_reg_lo_reg[PPCX_IE1_BIT] <= sfr_wdata[PPCX_IE1_BIT];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ie_bits_reg <= 2'h0;
         ea_reg      <= 1'b0;
      end else if (wr_ok && sfr_addr == PPCX_ADDR_IE) begin
         ie_bits_reg <= {sfr_wdata[PPCX_EX1_BIT], sfr_wdata[PPCX_EX0_BIT]};
         ea_reg      <= sfr_wdata[PPCX_EA_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ext_irq0_req <= 1'b0;
         ext_irq1_req <= 1'b0;
         wake_req     <= 1'b0;
      end else begin
         ext_irq0_req <= timer_control_reg_lo_reg[PPCX_IE0_BIT] && ie_bits_reg[0] && ea_reg;
         ext_irq1_req <= timer_control_reg_lo_reg[PPCX_IE1_BIT] && ie_bits_reg[1] && ea_reg;
         // Wake does not need the global enable: clock may be stopped
         wake_req     <= (timer_control_reg_lo_reg[PPCX_IE0_BIT] && ie_bits_reg[0])
                         || (timer_control_reg_lo_reg[PPCX_IE1_BIT] && ie_bits_reg[1]);
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   always_comb begin
      rdata_next = 8'h00;
      if (sfr_addr == PPCX_ADDR_PORT0) begin
         rdata_next = sfr_rmw ? port0_latch : port0_pins;
      end else if (sfr_addr == PPCX_ADDR_PORT1) begin
         rdata_next = sfr_rmw ? port1_latch : port1_pins;
      end else if (sfr_addr == PPCX_ADDR_PORT3) begin
         rdata_next = sfr_rmw ? port3_latch : port3_pins;
      end else if (sfr_addr == PPCX_ADDR_PORT2) begin
         rdata_next = {7'h00, reset_pin_disable && pin20_in};
      end else if (cfg_hit(sfr_addr, PPCX_ADDR_P0_ITYPE, cfg_page)) begin
         rdata_next = port0_input_type;
      end else if (cfg_hit(sfr_addr, PPCX_ADDR_P1_ITYPE, cfg_page)) begin
         rdata_next = port1_input_type;
      end else if (cfg_hit(sfr_addr, PPCX_ADDR_P3_ITYPE, cfg_page)) begin
         rdata_next = port3_input_type;
      end else if (cfg_hit(sfr_addr, PPCX_ADDR_P0_SLEW, cfg_page)) begin
         rdata_next = port0_slew_select;
      end else if (cfg_hit(sfr_addr, PPCX_ADDR_P1_SLEW, cfg_page)) begin
         rdata_next = port1_slew_select;
      end else if (cfg_hit(sfr_addr, PPCX_ADDR_P3_SLEW, cfg_page)) begin
         rdata_next = port3_slew_select;
      end else if (sfr_addr == PPCX_ADDR_P2_SET) begin
         rdata_next = p2_set_reg;
      end else if (sfr_addr == PPCX_ADDR_TIMER_CONTROL_REG) begin
         rdata_next = {4'h0, timer_control_reg_lo_reg};
      end else if (sfr_addr == PPCX_ADDR_IE) begin
         rdata_next = {ea_reg, 4'h0, ie_bits_reg[1], 1'b0, ie_bits_reg[0]};
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd || sfr_rmw) begin
         sfr_rdata <= rdata_next;
      end
   end

endmodule

`default_nettype wire
